// [rtl/tpe_timer.sv]
// Timer core: period measurement, event count and bypass modes,
// with its register slave on the internal module bus.
// Assumes the bus decodes the timer base and gives byte offsets,
// answers long words as two word accesses, and that pins are async.
`timescale 1ns/1ps
module tpe_timer
  import tpe_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        bus_sel_i,
  input  wire logic        bus_wr_i,
  input  wire logic [5:0]  bus_addr_i,
  input  wire logic [1:0]  bus_be_i,
  input  wire logic [15:0] bus_wdata_i,
  output logic      [15:0] bus_rdata_o,
  output logic             bus_ack_o,
  input  wire logic        iack_i,
  input  wire logic [2:0]  iack_level_i,
  input  wire logic [3:0]  iack_arb_i,
  output logic             iack_ack_o,
  output logic      [7:0]  iack_vector_o,
  output logic      [2:0]  interrupt_request_line_o,
  input  wire logic        gate_input_pin_n_i,
  input  wire logic        count_input_pin_i,
  input  wire logic        wave_output_pin_i,
  output logic             wave_output_pin_o,
  output logic             wave_output_pin_oe_n_o
);

  // ==========================================================
  // Declarations
  logic [15:0]   mcfg_r;
  logic [15:0]   vlvl_r;
  logic [15:0]   timer_control_reg;
  logic [15:0]   reload1_r;
  logic [15:0]   reload2_r;
  logic [15:0]   match_threshold_reg;
  logic [15:0]   cnt_r;
  logic [7:0]    pre_r;
  logic          loaded_r;
  logic          reload_due_r;
  logic          half_r;
  logic          selclk_q_r;
  logic          gate_q_r;
  logic          expiry_r;
  logic          match_r;
  logic          gate_evt_r;
  logic          seen_r;
  logic          running_r;
  logic          wave_r;
  tpe_pm_state_t pm_r;
  tpe_pm_state_t pm_nxt;
  logic [2:0]    pins_s;
  logic          gate_s;
  logic          tin_s;
  logic          pin_s;

  logic          run_bit;
  logic          gate_use;
  logic          clk_gate;
  logic [2:0]    mode;
  logic [1:0]    drive;
  logic [2:0]    tap;
  logic          wr_hit;
  logic          wr_ctl;
  logic          wr_sts;
  logic          selclk;
  logic          sel_fall;
  logic          run_en;
  logic          run_nxt;
  logic          pre_fall;
  logic          cnt_edge;
  logic [15:0]   cnt_dec;
  logic [7:0]    pre_dec;
  logic          hit_zero;
  logic          hit_match;
  logic          gate_asrt;
  logic          gate_negt;
  logic          gate_evt_set;
  logic          irq_pend;
  logic          bypass;
  logic [15:0]   status;

  assign run_bit  = timer_control_reg[CR_RUN_RELEASE];
  assign gate_use = timer_control_reg[CR_GATE_USE];
  assign clk_gate = timer_control_reg[CR_CLK_GATE_EN];
  assign mode     = timer_control_reg[CR_MODE_HI:CR_MODE_LO];
  assign drive    = timer_control_reg[CR_DRIVE_HI:CR_DRIVE_LO];
  assign tap      = timer_control_reg[CR_TAP_HI:CR_TAP_LO];
  assign bypass   = (mode == MODE_BYPASS);

  // ==========================================================
  // Pin synchronisers; gate is active low at the pin
  tpe_sync #(
    .WIDTH     (3),
    .RST_LEVEL (3'b011)
  ) u_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .ce_i    (ce_i),
    .async_i ({wave_output_pin_i, count_input_pin_i,
               gate_input_pin_n_i}),
    .sync_o  (pins_s)
  );
  assign gate_s = ~pins_s[0];
  assign tin_s  = pins_s[1];
  assign pin_s  = pins_s[2];

  // Gate edges seen on the synchronised level only
  assign gate_asrt = gate_s & ~gate_q_r;
  assign gate_negt = ~gate_s & gate_q_r;

  // ==========================================================
  // Selected clock and its falling edge
  always_comb
  begin
    if (!clk_gate)
      selclk = 1'b1;
    else if (timer_control_reg[CR_CLK_SOURCE])
      selclk = tin_s;
    else
      selclk = half_r;
  end
  assign sel_fall = selclk_q_r & ~selclk;

  // Half-rate clock and edge history
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      half_r     <= 1'b0;
      selclk_q_r <= 1'b1;
      gate_q_r   <= 1'b0;
    end
    else if (ce_i)
    begin
      half_r     <= ~half_r;
      selclk_q_r <= selclk;
      gate_q_r   <= gate_s;
    end
  end

  // ==========================================================
  // Period measurement sequence
  always_comb
  begin
    pm_nxt = pm_r;
    case (pm_r)
      TPE_PM_WAIT:
        if (gate_s)
          pm_nxt = TPE_PM_FIRST;
      TPE_PM_FIRST:
        if (gate_negt)
          pm_nxt = TPE_PM_SECOND;
      TPE_PM_SECOND:
        if (gate_asrt)
          pm_nxt = TPE_PM_DONE;
      TPE_PM_DONE:
        pm_nxt = TPE_PM_DONE;
      default:
        pm_nxt = TPE_PM_WAIT;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      pm_r <= TPE_PM_WAIT;
    else if (ce_i)
    begin
      if (!(run_bit && clk_gate && gate_use && mode == MODE_PERIOD))
        pm_r <= TPE_PM_WAIT;
      else
        pm_r <= pm_nxt;
    end
  end

  // ==========================================================
  // Counting enable per mode; other modes stay idle
  always_comb
  begin
    case (mode)
      MODE_PERIOD:
        run_en = run_bit && clk_gate && gate_use &&
                 (pm_r == TPE_PM_FIRST || pm_r == TPE_PM_SECOND);
      MODE_EVENT:
        run_en = run_bit && clk_gate && (!gate_use || gate_s);
      MODE_BYPASS:
        run_en = 1'b0;
      default:
        run_en = 1'b0;
    endcase
  end

  // Running flag: bypass shows the gate, else the enable
  assign run_nxt = bypass ? (clk_gate && gate_s) : run_en;

  // Gate event sources; ungated event count never flags
  always_comb
  begin
    gate_evt_set = 1'b0;
    if (run_bit && clk_gate && gate_use)
    begin
      if (mode == MODE_PERIOD)
        gate_evt_set = (pm_r == TPE_PM_SECOND) && gate_asrt;
      else if (mode == MODE_EVENT)
        gate_evt_set = gate_negt;
    end
    if (bypass && clk_gate && gate_use &&
        timer_control_reg[CR_IE_LO+1])
      gate_evt_set = gate_negt;
  end

  // ==========================================================
  // Prescaler taps and the counter clock
  assign pre_dec = pre_r - 8'h01;
  always_comb
  begin
    if (tap == 3'b000)
      pre_fall = pre_r[7] & ~pre_dec[7];
    else
      pre_fall = pre_r[tap - 3'd1] & ~pre_dec[tap - 3'd1];
  end
  assign cnt_edge = run_en && sel_fall &&
                    (!timer_control_reg[CR_TAP_SEL_EN] || pre_fall);

  assign cnt_dec   = cnt_r - 16'h0001;
  assign hit_zero  = cnt_edge && loaded_r && !reload_due_r &&
                     (cnt_dec == CNT_ZERO);
  assign hit_match = cnt_edge && loaded_r && !reload_due_r &&
                     (cnt_dec == match_threshold_reg) && !hit_zero;

  // Prescaler runs only while counting is enabled
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      pre_r <= PRE_ALL_ONES;
    else if (ce_i)
    begin
      if (!run_bit)
        pre_r <= PRE_ALL_ONES;
      else if (run_en && sel_fall)
        pre_r <= pre_dec;
    end
  end

  // Counter: first edge and post-timeout edge load all ones
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      cnt_r        <= CNT_ZERO;
      loaded_r     <= 1'b0;
      reload_due_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!run_bit)
      begin
        cnt_r        <= CNT_ZERO;
        loaded_r     <= 1'b0;
        reload_due_r <= 1'b0;
      end
      else if (cnt_edge)
      begin
        if (!loaded_r || reload_due_r)
        begin
          cnt_r        <= CNT_ALL_ONES;
          loaded_r     <= 1'b1;
          reload_due_r <= 1'b0;
        end
        else
        begin
          cnt_r        <= cnt_dec;
          reload_due_r <= hit_zero;
        end
      end
    end
  end

  // ==========================================================
  // Status flags; a set in the clearing cycle wins
  assign wr_hit = bus_sel_i && bus_wr_i;
  assign wr_ctl = wr_hit && bus_addr_i == OFS_CONTROL;
  assign wr_sts = wr_hit && bus_addr_i == OFS_STATUS && bus_be_i[1];

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      expiry_r   <= 1'b0;
      match_r    <= 1'b0;
      gate_evt_r <= 1'b0;
      seen_r     <= 1'b0;
      running_r  <= 1'b0;
    end
    else if (ce_i)
    begin
      expiry_r   <= (expiry_r & ~(wr_sts & bus_wdata_i[SR_EXPIRY]))
                    | hit_zero;
      match_r    <= (match_r & ~(wr_sts & bus_wdata_i[SR_MATCH]))
                    | hit_match;
      gate_evt_r <= (gate_evt_r & ~(wr_sts & bus_wdata_i[SR_GATE_EVT]))
                    | gate_evt_set;
      if (!run_bit || hit_zero)
        seen_r <= 1'b0;
      else if (hit_match)
        seen_r <= 1'b1;
      running_r  <= run_nxt;
    end
  end

  // ==========================================================
  // Wave output pin; output enable is low while driving
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      wave_r                 <= 1'b0;
      wave_output_pin_o      <= 1'b0;
      wave_output_pin_oe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      if (!run_bit)
        wave_r <= (drive == DRV_HIGH);
      else if (hit_zero && drive == DRV_TOGGLE)
        wave_r <= ~wave_r;
      if (bypass && (run_bit || !clk_gate))
      begin
        // Static level is only changed with the run bit low
        wave_output_pin_o      <= wave_output_pin_o;
        wave_output_pin_oe_n_o <= wave_output_pin_oe_n_o;
      end
      else
      begin
        wave_output_pin_o      <= wave_r;
        wave_output_pin_oe_n_o <= (drive == DRV_OFF);
      end
    end
  end

  // ==========================================================
  // Register writes; byte lanes honoured, read-only data dropped
  function automatic logic [15:0] tpe_merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0]  be,
    input logic [15:0] mask
  );
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & mask;
    return (old_v & ~m) | (new_v & m);
  endfunction : tpe_merge

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      mcfg_r              <= RST_MODULE_CFG;
      vlvl_r              <= RST_VECTOR_LEVEL;
      timer_control_reg   <= RST_CONTROL;
      reload1_r           <= CNT_ZERO;
      reload2_r           <= CNT_ZERO;
      match_threshold_reg <= CNT_ZERO;
    end
    else if (ce_i && wr_hit)
    begin
      case (bus_addr_i)
        OFS_MODULE_CFG:
          mcfg_r <= tpe_merge(mcfg_r, bus_wdata_i, bus_be_i,
                              MASK_MODULE_CFG);
        OFS_VECTOR_LEVEL:
          vlvl_r <= tpe_merge(vlvl_r, bus_wdata_i, bus_be_i,
                              MASK_VECTOR_LVL);
        OFS_CONTROL:
          timer_control_reg <= tpe_merge(timer_control_reg,
                                         bus_wdata_i, bus_be_i, 16'hFFFF);
        OFS_RELOAD_1:
          reload1_r <= tpe_merge(reload1_r, bus_wdata_i, bus_be_i,
                                 16'hFFFF);
        OFS_RELOAD_2:
          reload2_r <= tpe_merge(reload2_r, bus_wdata_i, bus_be_i,
                                 16'hFFFF);
        OFS_MATCH:
          match_threshold_reg <= tpe_merge(match_threshold_reg,
                                           bus_wdata_i, bus_be_i,
                                           16'hFFFF);
        default:
          ;
      endcase
    end
  end

  // ==========================================================
  // Status word; bypass masks counting flags and taps
  assign irq_pend = (timer_control_reg[CR_IE_HI] && expiry_r) ||
                    (timer_control_reg[CR_IE_LO+1] && gate_evt_r) ||
                    (timer_control_reg[CR_IE_LO] && match_r);
  always_comb
  begin
    status                = 16'h0000;
    status[SR_IRQ_PEND]   = irq_pend;
    status[SR_EXPIRY]     = expiry_r && !bypass;
    status[SR_GATE_EVT]   = gate_evt_r;
    status[SR_MATCH]      = match_r && !bypass;
    status[SR_GATE_LVL]   = pins_s[0]; // pin level, high if negated
    status[SR_RUNNING]    = running_r;
    status[SR_PIN_LVL]    = pin_s;
    status[SR_MATCH_SEEN] = seen_r && !bypass;
    status[7:0]           = bypass ? PRE_ALL_ONES : pre_r;
  end

  // Read data and acknowledge one cycle after the request
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      bus_rdata_o <= 16'h0000;
      bus_ack_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      bus_ack_o <= bus_sel_i;
      if (bus_sel_i && !bus_wr_i)
      begin
        case (bus_addr_i)
          OFS_MODULE_CFG:   bus_rdata_o <= mcfg_r;
          OFS_VECTOR_LEVEL: bus_rdata_o <= vlvl_r;
          OFS_CONTROL:      bus_rdata_o <= timer_control_reg;
          OFS_STATUS:       bus_rdata_o <= status;
          OFS_COUNT_VALUE:  bus_rdata_o <= cnt_r;
          OFS_RELOAD_1:     bus_rdata_o <= reload1_r;
          OFS_RELOAD_2:     bus_rdata_o <= reload2_r;
          OFS_MATCH:        bus_rdata_o <= match_threshold_reg;
          default:          bus_rdata_o <= 16'h0000;
        endcase
      end
      else
        bus_rdata_o <= 16'h0000;
    end
  end

  // ==========================================================
  // Interrupt request and acknowledge arbitration.
  // Zero arbitration priority never wins, so an unset module stays out.
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      interrupt_request_line_o <= 3'b000;
      iack_ack_o               <= 1'b0;
      iack_vector_o            <= 8'h00;
    end
    else if (ce_i)
    begin
      interrupt_request_line_o <= irq_pend ?
                                  vlvl_r[VL_LVL_HI:VL_LVL_LO] : 3'b000;
      iack_ack_o    <= iack_i && irq_pend &&
                       iack_level_i == vlvl_r[VL_LVL_HI:VL_LVL_LO] &&
                       mcfg_r[MC_ARB_HI:0] > iack_arb_i;
      iack_vector_o <= vlvl_r[VL_VEC_HI:0];
    end
  end

endmodule : tpe_timer

// [shared/tpe_pkg.sv]
// Constants for the period, event-count and bypass timer block.
// Assumes a 16-bit internal module bus that decodes the timer base
// and presents the byte offset within the timer window.
package tpe_pkg;

  // ==========================================================
  // Register byte offsets inside the timer window
  localparam logic [5:0] OFS_MODULE_CFG   = 6'h00;
  localparam logic [5:0] OFS_VECTOR_LEVEL = 6'h04;
  localparam logic [5:0] OFS_CONTROL      = 6'h06;
  localparam logic [5:0] OFS_STATUS       = 6'h08;
  localparam logic [5:0] OFS_COUNT_VALUE  = 6'h0A;
  localparam logic [5:0] OFS_RELOAD_1     = 6'h0C;
  localparam logic [5:0] OFS_RELOAD_2     = 6'h0E;
  localparam logic [5:0] OFS_MATCH        = 6'h10;

  // ==========================================================
  // Values after reset and writable masks
  localparam logic [15:0] RST_MODULE_CFG   = 16'h0080;
  localparam logic [15:0] RST_VECTOR_LEVEL = 16'h000F;
  localparam logic [15:0] RST_CONTROL      = 16'h0000;
  localparam logic [15:0] MASK_MODULE_CFG  = 16'hE08F;
  localparam logic [15:0] MASK_VECTOR_LVL  = 16'h07FF;

  // ==========================================================
  // Control register field positions
  localparam int CR_RUN_RELEASE = 15;
  localparam int CR_IE_HI       = 14;
  localparam int CR_IE_LO       = 12;
  localparam int CR_GATE_USE    = 11;
  localparam int CR_TAP_SEL_EN  = 10;
  localparam int CR_CLK_GATE_EN = 9;
  localparam int CR_CLK_SOURCE  = 8;
  localparam int CR_TAP_HI      = 7;
  localparam int CR_TAP_LO      = 5;
  localparam int CR_MODE_HI     = 4;
  localparam int CR_MODE_LO     = 2;
  localparam int CR_DRIVE_HI    = 1;
  localparam int CR_DRIVE_LO    = 0;

  // ==========================================================
  // Status register field positions (low byte is the prescaler)
  localparam int SR_IRQ_PEND  = 15;
  localparam int SR_EXPIRY    = 14;
  localparam int SR_GATE_EVT  = 13;
  localparam int SR_MATCH     = 12;
  localparam int SR_GATE_LVL  = 11;
  localparam int SR_RUNNING   = 10;
  localparam int SR_PIN_LVL   = 9;
  localparam int SR_MATCH_SEEN = 8;

  // Module configuration and vector register fields
  localparam int MC_ARB_HI  = 3;
  localparam int VL_LVL_HI  = 10;
  localparam int VL_LVL_LO  = 8;
  localparam int VL_VEC_HI  = 7;

  // ==========================================================
  // Operating modes and pin drive codes
  localparam logic [2:0] MODE_PERIOD = 3'b101;
  localparam logic [2:0] MODE_EVENT  = 3'b110;
  localparam logic [2:0] MODE_BYPASS = 3'b111;
  localparam logic [1:0] DRV_OFF     = 2'b00;
  localparam logic [1:0] DRV_TOGGLE  = 2'b01;
  localparam logic [1:0] DRV_HIGH    = 2'b11;

  // ==========================================================
  // Counter and prescaler load values
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [7:0]  PRE_ALL_ONES = 8'hFF;

  // Period measurement sequence
  typedef enum logic [1:0] {
    TPE_PM_WAIT,
    TPE_PM_FIRST,
    TPE_PM_SECOND,
    TPE_PM_DONE
  } tpe_pm_state_t;

endpackage : tpe_pkg

// [rtl/tpe_sync.sv]
// Two-flop synchroniser for a group of pin levels.
// Assumes the pins are asynchronous to clock_i; only the second
// stage may be read by other logic.
`timescale 1ns/1ps
module tpe_sync #(
  parameter int                 WIDTH     = 3,
  parameter logic [WIDTH-1:0]   RST_LEVEL = '1
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  // ==========================================================
  // Two stages; first stage feeds only the second
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      meta_r <= RST_LEVEL;
      sync_o <= RST_LEVEL;
    end
    else if (ce_i)
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : tpe_sync

// [dv/tpe_timer_chk.sv]
// Bus and acknowledge checks for the timer core.
// Assumes it is bound to the timer core and sees its ports only.
`timescale 1ns/1ps
module tpe_timer_chk (
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        ce_i,
  input wire logic        bus_sel_i,
  input wire logic        bus_ack_o,
  input wire logic [15:0] bus_rdata_o,
  input wire logic        iack_i,
  input wire logic [2:0]  iack_level_i,
  input wire logic        iack_ack_o,
  input wire logic [2:0]  interrupt_request_line_o,
  input wire logic        wave_output_pin_oe_n_o
);
  // ==========================================================
  // Properties; reset masks every check
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_ack_next_cycle: assert property (bus_sel_i && ce_i |=> bus_ack_o)
    else $error("bus access not answered in the next cycle");
  a_ack_has_cause: assert property (bus_ack_o |-> $past(bus_sel_i))
    else $error("bus answer without a request");
  a_ack_one_cycle: assert property (bus_ack_o && !bus_sel_i |=> !bus_ack_o)
    else $error("bus answer stands too long");
  a_rdata_quiet: assert property (!bus_ack_o |-> bus_rdata_o == 16'h0000)
    else $error("read data outside the answer cycle");
  a_iack_has_cause: assert property (iack_ack_o |-> $past(iack_i))
    else $error("vector supplied without acknowledge cycle");
  a_iack_level_match: assert property (iack_ack_o |->
    $past(iack_level_i) == $past(interrupt_request_line_o) &&
    $past(interrupt_request_line_o) != 3'd0)
    else $error("vector supplied for another level");
  a_iack_one_pulse: assert property (iack_ack_o && !iack_i |=> !iack_ack_o)
    else $error("vector answer stands too long");
  a_oe_after_reset: assert property ($rose(nrst_i) |-> wave_output_pin_oe_n_o)
    else $error("wave pin driven right after reset");
endmodule : tpe_timer_chk
bind tpe_timer tpe_timer_chk chk_u (
  .clock_i, .nrst_i, .ce_i, .bus_sel_i, .bus_ack_o, .bus_rdata_o, .iack_i,
  .iack_level_i, .iack_ack_o, .interrupt_request_line_o,
  .wave_output_pin_oe_n_o
);

// [dv/tpe_cpu_model.sv]
// Processor model: one register access or vector fetch at a time.
// Assumes the timer answers one cycle after it takes a request.
`timescale 1ns/1ps
module tpe_cpu_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] bus_rdata_i,
  input  wire logic        iack_ack_i,
  input  wire logic [7:0]  iack_vector_i,
  output logic             bus_sel_o,
  output logic             bus_wr_o,
  output logic [5:0]       bus_addr_o,
  output logic [15:0]      bus_wdata_o,
  output logic             iack_o,
  output logic [2:0]       iack_level_o,
  output logic [3:0]       iack_arb_o
);
  // ==========================================================
  // Requests last one taking edge; released lines show junk
  initial {bus_sel_o, bus_wr_o, bus_addr_o, bus_wdata_o} = '0;
  initial {iack_o, iack_level_o, iack_arb_o} = '0;
  task automatic access(input logic w, input logic [5:0] a,
                        input logic [15:0] d, output logic [15:0] r);
    @(posedge clock_i);
    {bus_sel_o, bus_wr_o, bus_addr_o, bus_wdata_o} <= {1'b1, w, a, d};
    @(posedge clock_i);
    {bus_sel_o, bus_wr_o, bus_addr_o, bus_wdata_o} <= {1'b0, ~w, ~a, ~d};
    @(posedge clock_i);
    r = bus_rdata_i;
  endtask : access
  task automatic iack_cycle(input logic [2:0] l, input logic [3:0] p,
                            output logic [8:0] r);
    @(posedge clock_i);
    {iack_o, iack_level_o, iack_arb_o} <= {1'b1, l, p};
    @(posedge clock_i);
    {iack_o, iack_level_o, iack_arb_o} <= {1'b0, ~l, ~p};
    @(posedge clock_i);
    r = {iack_ack_i, iack_vector_i};
  endtask : iack_cycle
endmodule : tpe_cpu_model

// [dv/tb_timer_period_event_bypass.sv]
// Bench for the timer core: registers, bypass pins, counting modes.
// Assumes a pull-up on the wave pin and a fixed-seed random source.
`timescale 1ns/1ps
module tb_timer_period_event_bypass import tpe_pkg::*;;
  logic        clock_i, nrst_i, ce_i, bus_sel_i, bus_wr_i, bus_ack_o, iack_i;
  logic        iack_ack_o, gate_input_pin_n_i, count_input_pin_i;
  logic        wave_output_pin_i, wave_output_pin_o, wave_output_pin_oe_n_o;
  logic [5:0]  bus_addr_i;
  logic [1:0]  bus_be_i;
  logic [15:0] bus_wdata_i, bus_rdata_o, rd, rd0;
  logic [2:0]  iack_level_i, interrupt_request_line_o;
  logic [3:0]  iack_arb_i;
  logic [7:0]  iack_vector_o;
  logic [8:0]  ia;
  logic [31:0] lfsr;
  int          fail_count, check_count, n;
  // ==========================================================
  // Wiring; pin reads high when released
  assign ce_i = 1'b1;
  assign bus_be_i = 2'b11;
  assign wave_output_pin_i = wave_output_pin_oe_n_o ? 1'b1 : wave_output_pin_o;
  tpe_timer dut_u (
    .clock_i, .nrst_i, .ce_i, .bus_sel_i, .bus_wr_i, .bus_addr_i, .bus_be_i,
    .bus_wdata_i, .bus_rdata_o, .bus_ack_o, .iack_i, .iack_level_i,
    .iack_arb_i, .iack_ack_o, .iack_vector_o, .interrupt_request_line_o,
    .gate_input_pin_n_i, .count_input_pin_i, .wave_output_pin_i,
    .wave_output_pin_o, .wave_output_pin_oe_n_o
  );
  tpe_cpu_model cpu_u (
    .clock_i, .bus_rdata_i(bus_rdata_o), .iack_ack_i(iack_ack_o),
    .iack_vector_i(iack_vector_o), .bus_sel_o(bus_sel_i),
    .bus_wr_o(bus_wr_i), .bus_addr_o(bus_addr_i), .bus_wdata_o(bus_wdata_i),
    .iack_o(iack_i), .iack_level_o(iack_level_i), .iack_arb_o(iack_arb_i)
  );
  // Expectations and helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  function automatic logic [15:0] exp_count(input int k);
    return 16'hffff - 16'(k - 1); // First edge loads all ones
  endfunction : exp_count
  function automatic logic exp_pin(input int oc);
    return (oc == 0) || (oc == 3);
  endfunction : exp_pin
  task automatic check(input string nm, input logic [15:0] s, e);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic chk_reg(input string nm, input logic [5:0] a,
                         input logic [15:0] m, e);
    cpu_u.access(1'b0, a, 16'h0000, rd);
    check(nm, rd & m, e);
  endtask : chk_reg
  task automatic wreg(input logic [5:0] a, input logic [15:0] d);
    cpu_u.access(1'b1, a, d, rd);
  endtask : wreg
  // Count pin pulses slow enough for the pin synchroniser
  task automatic pulses(input int k);
    repeat (k)
    begin
      repeat (4) @(posedge clock_i);
      count_input_pin_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      count_input_pin_i <= 1'b1;
    end
  endtask : pulses
  task automatic test_done;
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  // Clock and watchdog
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial
  begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    test_done();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {nrst_i, gate_input_pin_n_i, count_input_pin_i} = 3'b011;
    lfsr = 32'h0000_591b;
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    chk_reg("vector", OFS_VECTOR_LEVEL, 16'hffff, RST_VECTOR_LEVEL);
    chk_reg("cfg", OFS_MODULE_CFG, 16'hffff, RST_MODULE_CFG);
    chk_reg("taps", OFS_STATUS, 16'h00ff, 16'h00ff);
    lfsr = next_rand(lfsr);
    wreg(OFS_COUNT_VALUE, lfsr[15:0]);
    chk_reg("count ro", OFS_COUNT_VALUE, 16'hffff, 16'h0000);
    wreg(6'h12, lfsr[31:16]);
    chk_reg("reserved", 6'h12, 16'hffff, 16'h0000);
    // Static pin drive in bypass, every drive code
    for (int oc = 0; oc < 4; oc++)
    begin
      wreg(OFS_CONTROL, 16'h021c | 16'(oc));
      repeat (2) @(posedge clock_i);
      check("oe_n", 16'(wave_output_pin_oe_n_o), 16'(oc == 0));
      check("wire", 16'(wave_output_pin_i), 16'(exp_pin(oc)));
      chk_reg("bypass st", OFS_STATUS, 16'h53ff, {6'h0, exp_pin(oc), 9'h0ff});
    end
    // Gate interrupt in bypass, won and lost arbitration
    lfsr = next_rand(lfsr);
    wreg(OFS_VECTOR_LEVEL, {8'h03, lfsr[7:0]});
    wreg(OFS_MODULE_CFG, 16'h0085);
    wreg(OFS_CONTROL, 16'h2a1c);
    gate_input_pin_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk_reg("running", OFS_STATUS, 16'h2c00, 16'h0400);
    gate_input_pin_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk_reg("gate evt", OFS_STATUS, 16'h2c00, 16'h2800);
    check("irq", 16'(interrupt_request_line_o), 16'h0003);
    cpu_u.iack_cycle(3'd3, 4'd2, ia);
    check("iack win", 16'(ia), {7'h01, lfsr[7:0]});
    cpu_u.iack_cycle(3'd3, 4'd7, ia);
    check("iack lose", 16'(ia[8]), 16'h0000);
    wreg(OFS_STATUS, 16'h0000);
    chk_reg("evt kept", OFS_STATUS, 16'h2000, 16'h2000);
    wreg(OFS_STATUS, 16'h2000);
    chk_reg("evt clear", OFS_STATUS, 16'h2000, 16'h0000);
    // Event count from the count pin with a match threshold
    n = 3 + int'(lfsr[11:8]);
    wreg(OFS_MATCH, exp_count(n));
    wreg(OFS_CONTROL, 16'h8318);
    pulses(n);
    chk_reg("events", OFS_COUNT_VALUE, 16'hffff, exp_count(n));
    chk_reg("match", OFS_STATUS, 16'h1100, 16'h1100);
    // Half system clock: one count every two cycles, reads four apart
    wreg(OFS_CONTROL, 16'h8218);
    cpu_u.access(1'b0, OFS_COUNT_VALUE, 16'h0000, rd0);
    @(posedge clock_i);
    chk_reg("half clk", OFS_COUNT_VALUE, 16'hffff, rd0 - 16'h0002);
    wreg(OFS_CONTROL, 16'h0318);
    chk_reg("swr count", OFS_COUNT_VALUE, 16'hffff, 16'h0000);
    chk_reg("swr st", OFS_STATUS, 16'h01ff, 16'h00ff);
    // Period: idle till gate, negation ignored, reassertion stops
    wreg(OFS_CONTROL, 16'h8b14);
    pulses(2);
    gate_input_pin_n_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    pulses(n);
    gate_input_pin_n_i <= 1'b1;
    pulses(3);
    gate_input_pin_n_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    pulses(4);
    chk_reg("period", OFS_COUNT_VALUE, 16'hffff, exp_count(n + 3));
    chk_reg("period st", OFS_STATUS, 16'h2400, 16'h2000);
    test_done();
  end
endmodule : tb_timer_period_event_bypass
